// ---- verilog/intop_defs.vh ----
/*
 * Constants of the interrupt and option control block: register
 * addresses, field positions, reset values.
 * Assumes an 8-bit data address and 8-bit data register port.
 */
`ifndef INTOP_DEFS_VH
`define INTOP_DEFS_VH

// Register addresses
`define INTOP_ADDR_OPTION 8'h81
`define INTOP_ADDR_INTCTL_B0 8'h0b
`define INTOP_ADDR_INTCTL_B1 8'h8b
`define INTOP_ADDR_EVT_STATUS 8'h87
`define INTOP_ADDR_EVT_MASK 8'h88

// Option configuration fields
`define INTOP_OPT_PULLUP_DIS 7
`define INTOP_OPT_EXT_EDGE 6
`define INTOP_OPT_TMR_SRC 5
`define INTOP_OPT_TMR_EDGE 4
`define INTOP_OPT_PSA 3
`define INTOP_OPT_RATE_HI 2
`define INTOP_OPT_RATE_LO 0

// Interrupt control fields
`define INTOP_IC_GIE 7
`define INTOP_IC_PERIPHERAL_IRQ_ENABLE 6
`define INTOP_IC_TIMER_OVERFLOW_IRQ_ENABLE 5
`define INTOP_IC_EXTIE 4
`define INTOP_IC_PCIE 3
`define INTOP_IC_TIMER_OVERFLOW_FLAG 2
`define INTOP_IC_EXTIF 1
`define INTOP_IC_PCIF 0

// Event status and mask fields
`define INTOP_EV_TMR 0
`define INTOP_EV_EXT 1
`define INTOP_EV_PC 2

// Reset values
`define INTOP_RST_OPTION 8'hff
`define INTOP_RST_INTCTL 8'h00
`define INTOP_RST_EVT 3'h0
`define INTOP_RST_RDATA 8'h00

`endif

// ---- verilog/intop_edge.v ----
/*
 * Edge detector for a pin level with a selectable edge.
 * Assumes the pin input is already synchronous to i_clk.
 */
`timescale 1ns/100ps

module intop_edge (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Pin and edge choice: 1 = rising, 0 = falling
    input wire i_pin,
    input wire i_rising,
    // One-cycle pulse on the chosen edge
    output wire o_edge
);

reg prev_r;

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        prev_r <= 1'b0;
    end else begin
        prev_r <= i_pin;
    end
end

assign o_edge = i_rising ? (i_pin & ~prev_r) : (~i_pin & prev_r);

endmodule

// ---- verilog/intop_prescale.v ----
/*
 * Shared timer/watchdog prescaler with an 8-bit count.
 * Assumes event inputs are one-cycle pulses synchronous to i_clk.
 */
`timescale 1ns/100ps

module intop_prescale #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Configuration
    input wire i_clear,
    input wire i_assign,
    input wire [2:0] i_rate,
    // Event sources
    input wire i_timer_event,
    input wire i_wdt_event,
    // Divided pulses
    output reg o_timer_inc,
    output reg o_wdt_out
);

reg [WIDTH-1:0] cnt_r;
reg [WIDTH-1:0] cnt_nxt;
reg fire;
wire ev;
wire [WIDTH-1:0] term;

function [WIDTH-1:0] low_mask;
    input [3:0] n;
    integer k;
    begin
        low_mask = {WIDTH{1'b0}};
        for (k = 0; k < WIDTH; k = k + 1) begin
            if (k < n) begin
                low_mask[k] = 1'b1;
            end
        end
    end
endfunction

assign term = i_assign ? low_mask({1'b0, i_rate}) : low_mask({1'b0, i_rate} + 4'h1);
assign ev = i_assign ? i_wdt_event : i_timer_event;

always @* begin
    cnt_nxt = cnt_r;
    fire = 1'b0;
    if (i_clear) begin
        cnt_nxt = {WIDTH{1'b0}};
    end else if (ev) begin
        if ((cnt_r & term) == term) begin
            cnt_nxt = {WIDTH{1'b0}};
            fire = 1'b1;
        end else begin
            cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        cnt_r <= {WIDTH{1'b0}};
        o_timer_inc <= 1'b0;
        o_wdt_out <= 1'b0;
    end else begin
        cnt_r <= cnt_nxt;
        // undivided timer when prescaler sits on the watchdog
        o_timer_inc <= i_assign ? i_timer_event : (fire & ~i_clear);
        o_wdt_out <= i_assign ? (fire & ~i_clear) : i_wdt_event;
    end
end

endmodule

// ---- verilog/intop_ctrl.v ----
/*
 * Interrupt control and option configuration registers of a small
 * 8-bit controller, with event edge detection and the shared prescaler.
 * Assumes a single-cycle register port and event inputs synchronous to i_clk.
 * Assumes the core pulses its vector and return strobes for one cycle, and
 * that pin levels are already clean, with no bounce left on them.
 */
// Functional notes
// - The option register has eight read/write bits, all set to one at reset.
// - The interrupt control register holds every enable and flag except the comparator's.
// - A flag sets on its event whatever its own enable and the global enable say.
// - The external pin flag is set by hardware, never cleared by it, only by a zero write.
// - The interrupt control register answers at two addresses, one per bank.
// - All interrupt control bits are read/write; bits 7..1 clear at reset, bit 0 undefined.
`timescale 1ns/100ps
`include "intop_defs.vh"

module intop_ctrl #(
    parameter PRESCALE_WIDTH = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Event sources
    input wire i_timer_overflow,
    input wire i_external_irq_pin,
    input wire i_port_change,
    input wire i_periph_irq,
    // Timer and watchdog clocking
    input wire i_timer_clock_pin,
    input wire i_cycle_tick,
    input wire i_wdt_tick,
    output wire o_timer_inc,
    output wire o_wdt_tick,
    // Core interrupt handshake
    input wire i_irq_ack,
    input wire i_irq_return,
    output wire o_cpu_irq,
    // Option outputs
    output wire o_port_pullup_disable,
    output wire o_ext_irq_edge_select,
    output wire o_timer_clock_source_select,
    output wire o_timer_source_edge_select,
    output wire o_prescaler_assign,
    output wire [2:0] o_prescaler_rate,
    // Flags and enables
    output wire o_global_irq_enable,
    output wire o_timer_overflow_flag,
    output wire o_ext_pin_irq_flag,
    output wire o_port_change_flag,
    // Sticky event interrupt
    output wire o_irq
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

reg [7:0] option_config_r;
reg [7:0] option_config_nxt;
reg [7:0] interrupt_control_r;
reg [7:0] interrupt_control_nxt;
reg [2:0] evt_status_r;
reg [2:0] evt_status_nxt;
reg [2:0] evt_mask_r;
reg [2:0] evt_mask_nxt;
reg [7:0] rdata_nxt;

wire hit_option;
wire hit_intctl;
wire hit_status;
wire hit_mask;
wire ext_edge;
wire tpin_edge;
wire timer_event;
wire [2:0] events;
wire opt_write;
wire ic_write;

////////////////////////////////////////////////////////////////////////////////
// Helpers

// A software write loads the bit, but a hardware event in the same cycle wins
function flag_next;
    input cur;
    input ev;
    input wr_en;
    input wbit;
    begin
        flag_next = cur;
        if (wr_en) begin
            flag_next = wbit;
        end
        if (ev) begin
            flag_next = 1'b1;
        end
    end
endfunction

// Three-bit registers read back with zeros above
function [7:0] pad3;
    input [2:0] v;
    begin
        pad3 = {5'h00, v};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Address decode

assign hit_intctl = (i_addr == `INTOP_ADDR_INTCTL_B0) || (i_addr == `INTOP_ADDR_INTCTL_B1);
assign hit_option = (i_addr == `INTOP_ADDR_OPTION);
assign hit_status = (i_addr == `INTOP_ADDR_EVT_STATUS);
assign hit_mask = (i_addr == `INTOP_ADDR_EVT_MASK);
assign opt_write = i_wr & hit_option;
assign ic_write = i_wr & hit_intctl;

////////////////////////////////////////////////////////////////////////////////
// Event detection

intop_edge u_ext_edge (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pin(i_external_irq_pin),
    .i_rising(option_config_r[`INTOP_OPT_EXT_EDGE]),
    .o_edge(ext_edge)
);

// Edge select high means the falling edge on the timer pin
intop_edge u_tpin_edge (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pin(i_timer_clock_pin),
    .i_rising(~option_config_r[`INTOP_OPT_TMR_EDGE]),
    .o_edge(tpin_edge)
);

assign timer_event = option_config_r[`INTOP_OPT_TMR_SRC] ? tpin_edge : i_cycle_tick;

assign events[`INTOP_EV_TMR] = i_timer_overflow;
assign events[`INTOP_EV_EXT] = ext_edge;
assign events[`INTOP_EV_PC] = i_port_change;

////////////////////////////////////////////////////////////////////////////////
// Prescaler

// Count restarts on any option write so a new rate starts clean
intop_prescale #(
    .WIDTH(PRESCALE_WIDTH)
) u_prescale (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_clear(opt_write),
    .i_assign(option_config_r[`INTOP_OPT_PSA]),
    .i_rate(option_config_r[`INTOP_OPT_RATE_HI:`INTOP_OPT_RATE_LO]),
    .i_timer_event(timer_event),
    .i_wdt_event(i_wdt_tick),
    .o_timer_inc(o_timer_inc),
    .o_wdt_out(o_wdt_tick)
);

////////////////////////////////////////////////////////////////////////////////
// Option register

always @* begin
    option_config_nxt = option_config_r;
    if (opt_write) begin
        option_config_nxt = i_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt control register

always @* begin
    interrupt_control_nxt = interrupt_control_r;
    if (ic_write) begin
        interrupt_control_nxt = i_wdata;
    end
    // Vectoring drops the global enable, return restores it
    if (i_irq_ack) begin
        interrupt_control_nxt[`INTOP_IC_GIE] = 1'b0;
    end else if (i_irq_return) begin
        interrupt_control_nxt[`INTOP_IC_GIE] = 1'b1;
    end
    interrupt_control_nxt[`INTOP_IC_TIMER_OVERFLOW_FLAG] = flag_next(interrupt_control_r[`INTOP_IC_TIMER_OVERFLOW_FLAG],
        events[`INTOP_EV_TMR], ic_write, i_wdata[`INTOP_IC_TIMER_OVERFLOW_FLAG]);
    // hardware only sets, set beats a clearing write
    interrupt_control_nxt[`INTOP_IC_EXTIF] = flag_next(interrupt_control_r[`INTOP_IC_EXTIF],
        events[`INTOP_EV_EXT], ic_write, i_wdata[`INTOP_IC_EXTIF]);
    interrupt_control_nxt[`INTOP_IC_PCIF] = flag_next(interrupt_control_r[`INTOP_IC_PCIF],
        events[`INTOP_EV_PC], ic_write, i_wdata[`INTOP_IC_PCIF]);
end

////////////////////////////////////////////////////////////////////////////////
// Sticky event status and mask

always @* begin
    evt_status_nxt = evt_status_r;
    evt_mask_nxt = evt_mask_r;
    if (i_wr && hit_status) begin
        evt_status_nxt = evt_status_r & ~i_wdata[2:0];
    end
    if (i_wr && hit_mask) begin
        evt_mask_nxt = i_wdata[2:0];
    end
    // Set wins over a write-one clear
    evt_status_nxt = evt_status_nxt | events;
end

assign o_irq = |(evt_status_r & evt_mask_r);

////////////////////////////////////////////////////////////////////////////////
// Read data

always @* begin
    rdata_nxt = `INTOP_RST_RDATA;
    if (i_rd) begin
        if (hit_option) begin
            rdata_nxt = option_config_r;
        end else if (hit_intctl) begin
            rdata_nxt = interrupt_control_r;
        end else if (hit_status) begin
            rdata_nxt = pad3(evt_status_r);
        end else if (hit_mask) begin
            rdata_nxt = pad3(evt_mask_r);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// State

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        option_config_r <= `INTOP_RST_OPTION;
    end else begin
        option_config_r <= option_config_nxt;
    end
end

// control bits cleared; bit 0 takes zero as its undefined value
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        interrupt_control_r <= `INTOP_RST_INTCTL;
    end else begin
        interrupt_control_r <= interrupt_control_nxt;
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        evt_status_r <= `INTOP_RST_EVT;
    end else begin
        evt_status_r <= evt_status_nxt;
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        evt_mask_r <= `INTOP_RST_EVT;
    end else begin
        evt_mask_r <= evt_mask_nxt;
    end
end

// Read data drop back to zero so a stale value is never seen
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_rdata <= `INTOP_RST_RDATA;
    end else begin
        o_rdata <= rdata_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs

// comparator request arrives only through the peripheral gate
assign o_cpu_irq = interrupt_control_r[`INTOP_IC_GIE] &
    ((interrupt_control_r[`INTOP_IC_TIMER_OVERFLOW_IRQ_ENABLE] & interrupt_control_r[`INTOP_IC_TIMER_OVERFLOW_FLAG]) |
     (interrupt_control_r[`INTOP_IC_EXTIE] & interrupt_control_r[`INTOP_IC_EXTIF]) |
     (interrupt_control_r[`INTOP_IC_PCIE] & interrupt_control_r[`INTOP_IC_PCIF]) |
     (interrupt_control_r[`INTOP_IC_PERIPHERAL_IRQ_ENABLE] & i_periph_irq));

assign o_port_pullup_disable = option_config_r[`INTOP_OPT_PULLUP_DIS];
assign o_ext_irq_edge_select = option_config_r[`INTOP_OPT_EXT_EDGE];
assign o_timer_clock_source_select = option_config_r[`INTOP_OPT_TMR_SRC];
assign o_timer_source_edge_select = option_config_r[`INTOP_OPT_TMR_EDGE];
assign o_prescaler_assign = option_config_r[`INTOP_OPT_PSA];
assign o_prescaler_rate = option_config_r[`INTOP_OPT_RATE_HI:`INTOP_OPT_RATE_LO];
assign o_global_irq_enable = interrupt_control_r[`INTOP_IC_GIE];
assign o_timer_overflow_flag = interrupt_control_r[`INTOP_IC_TIMER_OVERFLOW_FLAG];
assign o_ext_pin_irq_flag = interrupt_control_r[`INTOP_IC_EXTIF];
assign o_port_change_flag = interrupt_control_r[`INTOP_IC_PCIF];

endmodule

// ---- verif/intop_ctrl_asserts.sv ----
/* Port checker for intop_ctrl.
   Assumes it is bound to intop_ctrl and sees only its ports. */
`timescale 1ns/100ps
module intop_ctrl_chk (
    // Clock, reset, register port
    input wire i_clk,
    input wire i_nrst,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Events and handshake
    input wire i_timer_overflow,
    input wire i_port_change,
    input wire i_wdt_tick,
    input wire i_irq_ack,
    input wire i_irq_return,
    input wire o_wdt_tick,
    input wire o_irq,
    // Option and flags
    input wire o_port_pullup_disable,
    input wire o_ext_irq_edge_select,
    input wire o_timer_clock_source_select,
    input wire o_timer_source_edge_select,
    input wire o_prescaler_assign,
    input wire [2:0] o_prescaler_rate,
    input wire o_global_irq_enable,
    input wire o_timer_overflow_flag,
    input wire o_ext_pin_irq_flag,
    input wire o_port_change_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire [7:0] opt = {o_port_pullup_disable, o_ext_irq_edge_select,
        o_timer_clock_source_select, o_timer_source_edge_select,
        o_prescaler_assign, o_prescaler_rate};
    wire ic_sel = i_addr == 8'h0b || i_addr == 8'h8b;
    ////////////////////////////////////////////////////////////////////////
    AST_OPT_RESET: assert property ($rose(i_nrst) |-> opt == 8'hff)
        else $error("option not all ones after reset");
    AST_IC_RESET: assert property ($rose(i_nrst) |-> !o_global_irq_enable
        && !o_timer_overflow_flag && !o_ext_pin_irq_flag)
        else $error("control bits not clear after reset");
    AST_OPT_WR: assert property (i_wr && i_addr == 8'h81 |=> opt == $past(i_wdata))
        else $error("option write lost");
    AST_IC_WR: assert property (i_wr && ic_sel && !i_irq_ack && !i_irq_return
        |=> o_global_irq_enable == $past(i_wdata[7]))
        else $error("global enable write lost");
    AST_TMR_SET: assert property (i_timer_overflow |=> o_timer_overflow_flag)
        else $error("timer flag not set");
    AST_PC_SET: assert property (i_port_change |=> o_port_change_flag)
        else $error("port flag not set");
    AST_EXT_HOLD: assert property (o_ext_pin_irq_flag && !(i_wr && ic_sel
        && !i_wdata[1]) |=> o_ext_pin_irq_flag)
        else $error("ext flag cleared by hardware");
    AST_RD_IC: assert property (i_rd && ic_sel |=> o_rdata[7] == $past(o_global_irq_enable)
        && o_rdata[2:0] == $past({o_timer_overflow_flag, o_ext_pin_irq_flag,
        o_port_change_flag}))
        else $error("control read mismatch");
    AST_WDT_1TO1: assert property (o_prescaler_assign && o_prescaler_rate == 3'h0
        && i_wdt_tick && !i_wr |=> o_wdt_tick)
        else $error("watchdog not undivided");
    COV_EXT: cover property ($rose(o_ext_pin_irq_flag));
    COV_IRQ: cover property ($rose(o_irq));
    COV_WDT: cover property (o_wdt_tick);
endmodule
bind intop_ctrl intop_ctrl_chk chk (.*);

// ---- verif/intop_ctrl_test.sv ----
/* Register-level bench for intop_ctrl.
   Assumes a single-cycle register port; the bench drives every input
   itself at the rising clock edge. */
`timescale 1ns/100ps
module intop_ctrl_test;
    reg i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0;
    reg [7:0] i_addr = 0, i_wdata = 0;
    reg i_timer_overflow = 0, i_external_irq_pin = 0, i_port_change = 0;
    reg i_cycle_tick = 0, i_wdt_tick = 0;
    reg i_periph_irq = 0, i_timer_clock_pin = 0, i_irq_ack = 0, i_irq_return = 0;
    wire [7:0] o_rdata;
    wire [2:0] o_prescaler_rate;
    wire o_timer_inc, o_wdt_tick, o_cpu_irq, o_irq, o_port_pullup_disable;
    wire o_ext_irq_edge_select, o_timer_clock_source_select, o_timer_source_edge_select;
    wire o_prescaler_assign, o_global_irq_enable, o_timer_overflow_flag;
    wire o_ext_pin_irq_flag, o_port_change_flag;
    integer fails = 0, n_tests = 0, r, c;
    intop_ctrl DUT (.*);
    initial begin
        forever #4 i_clk = !i_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input [15:0] seen, input [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge i_clk);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 0;
        #1;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge i_clk);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 0;
        #1 check(o_rdata, e);
    endtask
    // Pin is a level and keeps the value given
    task pulse(input [2:0] m);
        @(posedge i_clk);
        i_timer_overflow <= m[0];
        i_external_irq_pin <= m[1];
        i_port_change <= m[2];
        @(posedge i_clk);
        i_timer_overflow <= 0;
        i_port_change <= 0;
        @(posedge i_clk);
    endtask
    task ticks(input w, input integer n, input integer e);
        integer i, c;
        c = 0;
        for (i = 0; i < n + 3; i = i + 1) begin
            @(posedge i_clk);
            i_cycle_tick <= !w && i < n;
            i_wdt_tick <= w && i < n;
            #1 c = c + (w ? o_wdt_tick : o_timer_inc);
        end
        check(c[15:0], e[15:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #800000 fails = fails + 1;
        summarize;
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_nrst <= 1;
        rd(8'h81, 8'hff);
        rd(8'h0b, 8'h00);
        $display("reset test done");
        wr(8'h81, 8'h5a);
        rd(8'h81, 8'h5a);
        wr(8'h8b, 8'hf8);
        rd(8'h0b, 8'hf8);
        wr(8'h0b, 8'h40);
        rd(8'h8b, 8'h40);
        $display("access test done");
        wr(8'h0b, 8'h00);
        wr(8'h81, 8'hff);
        pulse(3'h7);
        rd(8'h0b, 8'h07);
        check(o_cpu_irq, 0);
        repeat (5) @(posedge i_clk);
        rd(8'h8b, 8'h07);
        wr(8'h0b, 8'h05);
        rd(8'h0b, 8'h05);
        $display("flag test done");
        rd(8'h87, 8'h07);
        wr(8'h88, 8'h02);
        check(o_irq, 1);
        wr(8'h87, 8'h02);
        check(o_irq, 0);
        rd(8'h87, 8'h05);
        pulse(3'h0);
        pulse(3'h2);
        check(o_irq, 1);
        wr(8'h88, 8'h00);
        check(o_irq, 0);
        wr(8'h90, 8'hff);
        rd(8'h90, 8'h00);
        wr(8'h0b, 8'ha4);
        check(o_cpu_irq, 1);
        @(posedge i_clk);
        i_irq_ack <= 1;
        @(posedge i_clk);
        i_irq_ack <= 0;
        #1 check(o_cpu_irq, 0);
        @(posedge i_clk);
        i_irq_return <= 1;
        @(posedge i_clk);
        i_irq_return <= 0;
        #1 check(o_global_irq_enable, 1);
        wr(8'h0b, 8'hc0);
        @(posedge i_clk);
        i_periph_irq <= 1;
        #1 check(o_cpu_irq, 1);
        wr(8'h0b, 8'h80);
        check(o_cpu_irq, 0);
        @(posedge i_clk);
        i_periph_irq <= 0;
        $display("interrupt test done");
        for (r = 0; r < 8; r = r + 1) begin
            wr(8'h81, 8'hd0 | r[7:0]);
            ticks(0, 256, 256 >> (r + 1));
            wr(8'h81, 8'hd8 | r[7:0]);
            ticks(1, 256, 256 >> r);
            ticks(0, 64, 64);
        end
        wr(8'h81, 8'hf8);
        c = 0;
        for (r = 0; r < 16; r = r + 1) begin
            @(posedge i_clk);
            i_timer_clock_pin <= r[1] && r < 12;
            #1 c = c + o_timer_inc;
        end
        check(c[15:0], 16'h0003);
        $display("prescaler test done");
        summarize;
    end
endmodule
